// >>> design/addr_ctl_defines.svh
// constants for the address and program control block
`ifndef ADDR_CTL_DEFINES_SVH
`define ADDR_CTL_DEFINES_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_STATUS 8'h00
`define OFS_CLEAR  8'h04
`define OFS_ENABLE 8'h08
`define OFS_IMASK  8'h0C
`define OFS_STATE  8'h10
`define OFS_AUX0   8'h14
`define OFS_AUX1   8'h18
// ---------------------------------------------------------------
// status bits and widths
// ---------------------------------------------------------------
`define EV_OVF     0
`define EV_UNF     1
`define EV_BTL     2
`define EV_IRQ     3
`define EV_W       4
`define IRQ_N      15
`define NMI_BIT    14
`define PC_W       12
`define STK_DEPTH  4
`define IO_HIGH    9'h1FF
`define IRQ_VEC    12'h002
`define STARTUP    2'h2
// ---------------------------------------------------------------
// opcodes in instr[15:12]
// ---------------------------------------------------------------
`define OP_NOP   4'h0
`define OP_ARITH 4'h1
`define OP_MEM   4'h2
`define OP_MULI  4'h3
`define OP_LDAI  4'h4
`define OP_LDXI  4'h5
`define OP_LDP   4'h6
`define OP_LARP  4'h7
`define OP_BR    4'h8
`define OP_CALL  4'h9
`define OP_RET   4'hA
`define OP_BTL   4'hB
`define OP_IN    4'hC
`define OP_OUT   4'hD
`define OP_SPILL 4'hE
`define OP_FILL  4'hF
`endif

// >>> design/addr_ctl_pkg.sv
// types shared by the address and program control block
package addr_ctl_pkg;
  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_WAIT} st_type;
  typedef struct packed {
    logic       re;
    logic       we;
    logic [7:0] addr;
  } dmem_req_type;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
  } io_req_type;
endpackage : addr_ctl_pkg

// >>> design/aux_reg.sv
// one auxiliary pointer register with load and step
`timescale 1ns/1ps
`default_nettype none
module aux_reg (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        inc,
  input  wire logic        dec,
  // value
  output logic      [15:0] value
);
  logic [15:0] val_q;
  logic [15:0] val_d;
  assign val_d = load ? load_val :
                 inc  ? val_q + 16'h0001 :
                 dec  ? val_q - 16'h0001 : val_q;
  assign value = val_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) val_q <= 16'h0000;
    else          val_q <= val_d;
  end
endmodule : aux_reg
`default_nettype wire

// >>> design/ret_stack.sv
// four-deep return stack, top held in a register
`timescale 1ns/1ps
`default_nettype none
`include "addr_ctl_defines.svh"
module ret_stack (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // requests
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [11:0] push_val,
  // state
  output logic      [11:0] top,
  output logic      [2:0]  depth
);
  logic [11:0] ent_q [`STK_DEPTH];
  logic [2:0]  dep_q;
  assign top   = ent_q[0];
  assign depth = dep_q;
  // full push drops the oldest entry, empty pop yields zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `STK_DEPTH; i++) ent_q[i] <= 12'h000;
      dep_q <= 3'h0;
    end else if (push) begin
      ent_q[0] <= push_val;
      for (int i = 1; i < `STK_DEPTH; i++) ent_q[i] <= ent_q[i-1];
      if (dep_q != 3'(`STK_DEPTH)) dep_q <= dep_q + 3'h1;
    end else if (pop) begin
      for (int i = 0; i < `STK_DEPTH - 1; i++) ent_q[i] <= ent_q[i+1];
      ent_q[`STK_DEPTH-1] <= 12'h000;
      if (dep_q != 3'h0) dep_q <= dep_q - 3'h1;
    end
  end
endmodule : ret_stack
`default_nettype wire

// >>> design/dsp_addr_ctl.sv
// address generation and program control with apb status registers
`timescale 1ns/1ps
`default_nettype none
`include "addr_ctl_defines.svh"
module dsp_addr_ctl import addr_ctl_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // mode pin
  input  wire logic        mode_select_pin,
  // instruction issue
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  output logic             instr_ready,
  // interrupt sources
  input  wire logic [14:0] irq_req,
  output logic      [14:0] irq_ack,
  // program side
  output logic      [11:0] pc,
  output logic             prog_ext,
  // data and io side
  output dmem_req_type     dmem,
  output logic      [15:0] dmem_wdata,
  input  wire logic [15:0] mem_rdata,
  output io_req_type       io,
  output logic      [15:0] operand,
  output logic      [3:0]  shift_amt,
  output logic             intr
);
  // -------------------------------------------------------------
  // mode pin synchroniser and boot capture
  // -------------------------------------------------------------
  logic mode_s1_q, mode_s2_q, mode_q;
  logic [1:0] boot_q;
  st_type st_q, st_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      mode_s1_q <= mode_select_pin;
      mode_s2_q <= mode_s1_q;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 2'h0;
      mode_q <= 1'b0;
    end else if (st_q == ST_BOOT) begin
      boot_q <= boot_q + 2'h1;
      if (boot_q == `STARTUP) mode_q <= mode_s2_q;
    end
  end
  assign prog_ext = ~mode_q;

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  logic [3:0] op;
  logic       take, acc, ind, memop, imm, twocyc;
  logic [14:0] imask_q, pend;
  logic [3:0] irq_idx;
  logic       dpp_q, asel_q;
  logic [15:0] aux0, aux1, aux_sel;
  logic [11:0] stk_top;
  logic [2:0]  stk_dep;
  assign op = instr[15:12];
  // every memory op may go indirect
  assign memop = op == `OP_ARITH || op == `OP_MEM || op == `OP_IN
              || op == `OP_OUT || op == `OP_SPILL || op == `OP_FILL;
  assign ind = memop & instr[7];
  assign imm = op == `OP_MULI || op == `OP_LDAI || op == `OP_LDXI;
  // only branch-like and io ops take two cycles
  assign twocyc = op == `OP_BR || op == `OP_CALL || op == `OP_RET
               || op == `OP_BTL || op == `OP_IN || op == `OP_OUT;
  assign pend = irq_req & {1'b1, imask_q[13:0]};
  always_comb begin
    irq_idx = 4'd0;
    for (int i = 13; i >= 0; i--) if (pend[i]) irq_idx = 4'(i);
    if (pend[`NMI_BIT]) irq_idx = 4'(`NMI_BIT);
  end
  assign take = st_q == ST_RUN && |pend;
  assign instr_ready = st_q == ST_RUN && !take;
  assign acc = instr_valid & instr_ready;
  assign aux_sel = asel_q ? aux1 : aux0;

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_BOOT: if (boot_q == `STARTUP) st_d = ST_RUN;
      ST_RUN:  if (take || (acc && twocyc)) st_d = ST_WAIT;
      ST_WAIT: st_d = ST_RUN;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_q <= ST_BOOT;
    else          st_q <= st_d;
  end

  // -------------------------------------------------------------
  // return stack and pc
  // -------------------------------------------------------------
  logic push, pop;
  logic [11:0] push_val, pc_q;
  // save pc on call and irq entry
  assign push = take || (acc && (op == `OP_CALL || op == `OP_FILL));
  assign pop  = !take && acc && (op == `OP_RET || op == `OP_SPILL);
  // fill pushes a data word onto the stack
  assign push_val = take ? pc_q : (op == `OP_FILL) ? mem_rdata[11:0]
                                                   : pc_q + 12'h001;
  ret_stack u_stack (
    .pclk     (pclk),
    .presetn  (presetn),
    .push     (push),
    .pop      (pop),
    .push_val (push_val),
    .top      (stk_top),
    .depth    (stk_dep)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pc_q <= 12'h000;
    else if (take) pc_q <= `IRQ_VEC + {7'h00, irq_idx, 1'b0};
    else if (acc) begin
      unique case (op)
        `OP_BR, `OP_CALL: pc_q <= instr[11:0];
        `OP_RET:          pc_q <= stk_top;
        default:          pc_q <= pc_q + 12'h001;
      endcase
    end
  end
  assign pc = pc_q;
  assign irq_ack = take ? 15'(15'h0001 << irq_idx) : 15'h0000;

  // -------------------------------------------------------------
  // aux registers and data addressing
  // -------------------------------------------------------------
  logic ld0, ld1, stp_inc, stp_dec;
  assign ld0 = acc && op == `OP_LDXI && !instr[8];
  assign ld1 = acc && op == `OP_LDXI && instr[8];
  // step the selected aux alongside execution
  assign stp_inc = acc && ind && instr[5:4] == 2'b01;
  assign stp_dec = acc && ind && instr[5:4] == 2'b10;
  aux_reg u_aux0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (ld0),
    .load_val ({8'h00, instr[7:0]}),
    .inc      (stp_inc & ~asel_q),
    .dec      (stp_dec & ~asel_q),
    .value    (aux0)
  );
  aux_reg u_aux1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (ld1),
    .load_val ({8'h00, instr[7:0]}),
    .inc      (stp_inc & asel_q),
    .dec      (stp_dec & asel_q),
    .value    (aux1)
  );
  // page and select start at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dpp_q <= 1'b0;
      asel_q <= 1'b0;
    end else if (acc) begin
      if (op == `OP_LDP) dpp_q <= instr[0];
      if (op == `OP_LARP || (ind && instr[3])) asel_q <= instr[0];
    end
  end
  logic [7:0] daddr;
  // direct page plus offset; indirect aux low byte
  assign daddr = ind ? aux_sel[7:0] : {dpp_q, instr[6:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dmem       <= '0;
      dmem_wdata <= 16'h0000;
      io         <= '0;
      operand    <= 16'h0000;
      shift_amt  <= 4'h0;
    end else begin
      // input ops write the port word to ram, so no read strobe
      dmem.re  <= acc && memop && op != `OP_SPILL && op != `OP_OUT && op != `OP_IN;
      dmem.we  <= acc && (op == `OP_SPILL || op == `OP_IN);
      dmem.addr <= daddr;
      dmem_wdata <= {4'h0, stk_top};
      // io drives port only, upper lines high
      io.rd   <= acc && op == `OP_IN;
      io.wr   <= acc && op == `OP_OUT;
      io.addr <= {`IO_HIGH, instr[10:8]};
      operand <= op == `OP_MULI ? {4'h0, instr[11:0]} : {8'h00, instr[7:0]};
      // shift count issued with the operand
      shift_amt <= (acc && op == `OP_ARITH) ? instr[11:8] : 4'h0;
    end
  end

  // -------------------------------------------------------------
  // events and apb registers
  // -------------------------------------------------------------
  logic [`EV_W-1:0] ev, sts_q, en_q;
  logic wr, hit;
  // test branch burns two cycles and raises its status event
  assign ev[`EV_BTL] = acc && op == `OP_BTL;
  assign ev[`EV_OVF] = push && stk_dep == 3'(`STK_DEPTH);
  assign ev[`EV_UNF] = pop && stk_dep == 3'h0;
  assign ev[`EV_IRQ] = take;
  assign wr = psel & penable & pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q   <= '0;
      en_q    <= '0;
      imask_q <= 15'h0000;
    end else begin
      sts_q <= (sts_q & ~((wr && paddr == `OFS_CLEAR) ? pwdata[`EV_W-1:0] : '0)) | ev;
      if (wr && paddr == `OFS_ENABLE) en_q <= pwdata[`EV_W-1:0];
      if (wr && paddr == `OFS_IMASK) imask_q <= pwdata[14:0];
    end
  end
  assign intr = |(sts_q & en_q);
  assign hit = paddr == `OFS_STATUS || paddr == `OFS_CLEAR || paddr == `OFS_ENABLE
            || paddr == `OFS_IMASK || paddr == `OFS_STATE || paddr == `OFS_AUX0
            || paddr == `OFS_AUX1;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `OFS_STATUS: prdata = {28'h000_0000, sts_q};
      `OFS_ENABLE: prdata = {28'h000_0000, en_q};
      `OFS_IMASK:  prdata = {17'h0_0000, imask_q};
      `OFS_STATE:  prdata = {16'h0000, pc_q, mode_q, stk_dep[1:0] == 2'h0 && stk_dep[2],
                             dpp_q, asel_q};
      `OFS_AUX0:   prdata = {16'h0000, aux0};
      `OFS_AUX1:   prdata = {16'h0000, aux1};
      default:     prdata = 32'h0000_0000;
    endcase
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_MODE_MAP: assert property (
    st_q == ST_BOOT && boot_q == `STARTUP |=> prog_ext == !$past(mode_s2_q))
    else $error("program map not taken from mode pin");
  AST_MODE_HOLD: assert property (
    st_q != ST_BOOT && $past(st_q) != ST_BOOT |-> $stable(mode_q))
    else $error("program map changed after boot");
  AST_EXT_ALL: assert property (!mode_q && st_q != ST_BOOT |-> prog_ext)
    else $error("fetch not external in processor mode");
  AST_CALL_RET: assert property (
    acc && op == `OP_RET && stk_dep != 3'h0 |=> pc_q == $past(stk_top))
    else $error("return did not restore pc");
  AST_MASKED: assert property (
    irq_req[13:0] != 14'h0 && !irq_req[14] && (irq_req[13:0] & imask_q[13:0]) == 14'h0
    |-> !take)
    else $error("masked interrupt taken");
  AST_NMI: assert property (st_q == ST_RUN && irq_req[14] |-> irq_ack[14])
    else $error("nmi not taken");
  AST_IO_ADDR: assert property (io.rd || io.wr |-> io.addr[11:3] == `IO_HIGH)
    else $error("io upper lines not high");
  AST_BTL: assert property (
    acc && op == `OP_BTL |=> !instr_ready ##1 st_q == ST_RUN
    && pc_q == $past(pc_q, 2) + 12'h001)
    else $error("test branch not a two-cycle nop");
  AST_DIRECT: assert property (
    acc && memop && !ind |=> dmem.addr == {$past(dpp_q), $past(instr[6:0])})
    else $error("direct address wrong");
  AST_INDIRECT: assert property (acc && ind |=> dmem.addr == $past(aux_sel[7:0]))
    else $error("indirect address wrong");
  AST_STEP: assert property (
    acc && ind && instr[5:4] == 2'b01 && !instr[3] && !asel_q && !twocyc
    |=> aux0 == $past(aux0) + 16'h0001 && st_q == ST_RUN)
    else $error("aux step missing");
  AST_IMM: assert property (
    acc && op == `OP_LDAI |=> !dmem.re && operand == {8'h00, $past(instr[7:0])})
    else $error("immediate operand wrong");
  AST_IMM_NORD: assert property (acc && imm |=> !dmem.re && !dmem.we)
    else $error("immediate op touched data memory");
  AST_SHIFT: assert property (
    acc && op == `OP_ARITH |=> st_q == ST_RUN && shift_amt == $past(instr[11:8]))
    else $error("shift op took extra cycle");
  AST_SPILL: assert property (
    acc && op == `OP_SPILL |=> dmem.we && dmem_wdata[11:0] == $past(stk_top))
    else $error("spill wrote wrong word");
  COV_CALL_RET: cover property (acc && op == `OP_CALL ##[2:20] acc && op == `OP_RET);
  COV_IRQ: cover property (take);
  COV_OVF: cover property (ev[`EV_OVF]);
  COV_IND: cover property (acc && ind && instr[3]);
endmodule : dsp_addr_ctl
`default_nettype wire

// >>> dv/ext_mem.sv
// behavioural external data memory facing the address control block
`timescale 1ns/1ps
`default_nettype none
module ext_mem import addr_ctl_pkg::*; (
  // clock
  input  wire logic         pclk,
  // requests from the block
  input  wire dmem_req_type dmem,
  input  wire logic [15:0]  dmem_wdata,
  // read data back
  output logic      [15:0]  mem_rdata
);
  logic [15:0] ram [256];
  logic [15:0] last_q;
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (dmem.we) begin
      ram[dmem.addr] <= dmem_wdata;
    end
    last_q <= mem_rdata;
  end
  // not selected: show the inverse of the last output, so the stale value comes back on every second idle cycle
  assign mem_rdata = dmem.re ? ram[dmem.addr] : ~last_q;
endmodule : ext_mem
`default_nettype wire

// >>> dv/tb.sv
// self-checking testbench for the address and program control block
`timescale 1ns/1ps
`default_nettype none
`include "addr_ctl_defines.svh"
module tb import addr_ctl_pkg::*;;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic         mode_select_pin, instr_valid, instr_ready, prog_ext, intr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [15:0]  instr, mem_rdata, dmem_wdata, operand;
  logic [14:0]  irq_req, irq_ack;
  logic [11:0]  pc, p;
  logic [3:0]   shift_amt;
  dmem_req_type dmem;
  io_req_type   io;
  int           errors, n_compared, cycles;

  dsp_addr_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_select_pin(mode_select_pin), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .irq_req(irq_req), .irq_ack(irq_ack),
    .pc(pc), .prog_ext(prog_ext), .dmem(dmem), .dmem_wdata(dmem_wdata),
    .mem_rdata(mem_rdata), .io(io), .operand(operand), .shift_amt(shift_amt), .intr(intr));
  ext_mem mem (.pclk(pclk), .dmem(dmem), .dmem_wdata(dmem_wdata), .mem_rdata(mem_rdata));

  always #20 pclk = ~pclk;
  // ---------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic do_reset(input logic m);
    @(posedge pclk);
    presetn         <= 1'b0;
    mode_select_pin <= m;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
  endtask : do_reset
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    if (pslverr === 1'b1) rd = 32'hDEAD_0000;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one idle cycle before each request keeps every change on a rising edge
  task automatic issue(input logic [15:0] v);
    @(posedge pclk);
    instr       <= v;
    instr_valid <= 1'b1;
    do begin
      @(posedge pclk);
    end while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic wait_ack(input int i, input logic [11:0] v);
    do begin
      @(posedge pclk);
    end while (irq_ack[i] !== 1'b1);
    irq_req <= 15'h0000;
    #1;
    chk(16'(pc), 16'(v));
  endtask : wait_ack
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // page and shift
  task automatic s_direct();
    issue({`OP_LDP, 12'h001});
    issue({`OP_ARITH, 12'h525});
    chk(16'(dmem.addr), 16'h00A5);
    chk(16'(dmem.re), 16'h0001);
    chk(16'(shift_amt), 16'h0005);
    chk(16'(instr_ready), 16'h0001);
    issue({`OP_LDP, 12'h000});
  endtask : s_direct
  task automatic s_indirect();
    issue({`OP_LDXI, 12'h040});
    chk(operand, 16'h0040);
    issue({`OP_LDXI, 12'h177});
    issue({`OP_MEM, 12'h090});
    chk(16'(dmem.addr), 16'h0040);
    chk(16'(instr_ready), 16'h0001);
    issue({`OP_MEM, 12'h089});
    chk(16'(dmem.addr), 16'h0041);
    issue({`OP_MEM, 12'h0A0});
    chk(16'(dmem.addr), 16'h0077);
    issue({`OP_MEM, 12'h080});
    chk(16'(dmem.addr), 16'h0076);
    issue({`OP_LARP, 12'h000});
  endtask : s_indirect
  task automatic s_imm();
    issue({`OP_MULI, 12'hABC});
    chk(operand, 16'h0ABC);
    chk(16'(dmem.re), 16'h0000);
    issue({`OP_LDAI, 12'h0FF});
    chk(operand, 16'h00FF);
  endtask : s_imm
  task automatic s_call();
    p = pc;
    issue({`OP_CALL, 12'h100});
    chk(16'(pc), 16'h0100);
    chk(16'(instr_ready), 16'h0000);
    issue({`OP_SPILL, 12'h010});
    chk(16'(dmem.we), 16'h0001);
    chk(dmem_wdata, 16'(p + 12'h001));
    p = pc;
    issue({`OP_CALL, 12'h200});
    issue({`OP_RET, 12'h000});
    chk(16'(pc), 16'(p + 12'h001));
    apb(1'b1, `OFS_ENABLE, 32'h0000_0001);
    repeat (5) issue({`OP_CALL, 12'h300});
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(rd[15:0] & 16'h0001, 16'h0001);
    chk(16'(intr), 16'h0001);
    apb(1'b1, `OFS_CLEAR, 32'h0000_0001);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(rd[15:0] & 16'h0001, 16'h0000);
    chk(16'(intr), 16'h0000);
  endtask : s_call
  task automatic s_btl_io();
    p = pc;
    issue({`OP_BTL, 12'h000});
    chk(16'(instr_ready), 16'h0000);
    chk(16'(pc), 16'(p + 12'h001));
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(rd[15:0] & 16'h0004, 16'h0004);
    issue({`OP_IN, 12'h512});
    chk(16'(io.rd), 16'h0001);
    chk(16'(io.addr), 16'h0FFD);
    chk(16'(dmem.we), 16'h0001);
    issue({`OP_OUT, 12'h312});
    chk(16'(io.wr), 16'h0001);
    chk(16'(io.addr), 16'h0FFB);
    chk(16'(instr_ready), 16'h0000);
  endtask : s_btl_io
  task automatic s_irq();
    apb(1'b1, `OFS_ENABLE, 32'h0000_0008);
    @(posedge pclk);
    irq_req <= 15'h0008;
    repeat (6) begin
      @(posedge pclk);
      chk(16'(irq_ack), 16'h0000);
    end
    irq_req <= 15'h4008;
    wait_ack(14, 12'(`IRQ_VEC + 2 * 14));
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(rd[15:0] & 16'h0008, 16'h0008);
    chk(16'(intr), 16'h0001);
    apb(1'b1, `OFS_IMASK, 32'h0000_0008);
    irq_req <= 15'h0008;
    wait_ack(3, 12'(`IRQ_VEC + 2 * 3));
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd[31:16], 16'hDEAD);
  endtask : s_irq
  task automatic s_mode();
    chk(16'(prog_ext), 16'h0000);
    apb(1'b0, `OFS_STATE, 32'h0000_0000);
    chk(rd[15:0] & 16'h000B, 16'h0008);
    issue({`OP_RET, 12'h000});
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(rd[15:0] & 16'h0002, 16'h0002);
    issue({`OP_LDP, 12'h001});
    issue({`OP_LARP, 12'h001});
    do_reset(1'b0);
    chk(16'(prog_ext), 16'h0001);
    apb(1'b0, `OFS_STATE, 32'h0000_0000);
    chk(rd[15:0] & 16'h000B, 16'h0000);
  endtask : s_mode
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, instr_valid} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    instr = 16'h0000;
    irq_req = 15'h0000;
    mode_select_pin = 1'b1;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    do_reset(1'b1);
    s_mode();
    do_reset(1'b1);
    s_direct();
    s_indirect();
    s_imm();
    s_call();
    s_btl_io();
    s_irq();
    results();
  end
endmodule : tb
`default_nettype wire
